// *** logic/cmosc_ctrl.sv ***
// clock mode register, source selection and oscillation-stop reset logic
`timescale 1ns/1ps
`default_nettype none
module cmosc_ctrl
  import cmosc_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic MODE_WR,
  input wire logic MODE_BIT_OP,
  input wire logic [7:0] MODE_WDATA,
  output logic [7:0] MODE_RDATA,
  input wire logic MAIN_OSC_INPUT,
  input wire logic DET_ACTIVE_WR,
  input wire logic DET_ACTIVE_WDATA,
  input wire logic STOP_RST_EN_WR,
  input wire logic STOP_RST_EN_WDATA,
  output logic DET_ACTIVE,
  output logic STOP_RST_EN,
  output logic STOP_STATUS,
  output logic MODE_LOCKED,
  output logic USE_MAIN_OSC,
  output logic RC_MODE,
  output logic MAIN_OSC_RUN,
  output logic RING_OSC_RUN,
  output logic [1:0] DIV_SEL,
  output logic INT_RST
);
  logic [7:0] mode, next_mode;
  logic locked, next_locked;
  logic det_active, next_det_active;
  logic stop_rst_en, next_stop_rst_en;
  logic status, next_status;
  logic [7:0] rst_cnt, next_rst_cnt;
  logic stopped;
  logic [7:0] wmask;
  logic int_rst;
  cmosc_wr_t wr_kind;
  cmosc_src_t src, next_src;

  cmosc_stop_det u_det (
    .clk(CLK),
    .rst(SYS_RST),
    .enable(det_active),
    .osc_in(MAIN_OSC_INPUT),
    .stopped(stopped)
  );

  assign int_rst = rst_cnt != 8'h00;

  always_comb
  begin
    if (!MODE_WR)
      wr_kind = CMOSC_WR_NONE;
    else if (MODE_BIT_OP)
      wr_kind = CMOSC_WR_BIT;
    else
      wr_kind = CMOSC_WR_FULL;
  end

  always_comb
  begin
    // once-only bits drop out of the write mask after the first write
    wmask = locked ? ~CMOSC_ONCE_MASK : 8'hFF;
    next_mode = mode;
    next_locked = locked;
    next_src = src;
    if (wr_kind != CMOSC_WR_NONE)
    begin
      next_mode = (mode & ~wmask) | (MODE_WDATA & wmask);
      next_locked = 1'b1;
    end
    // a bit op rewrites the whole byte, so it locks even when aimed elsewhere
    next_src = next_mode[CMOSC_BIT_MAIN_STOP] ? CMOSC_SRC_RING
             : (next_mode[7:6] == CMOSC_DIV_RING8 ? CMOSC_SRC_RING
                                                  : CMOSC_SRC_MAIN);
    case (src)
      CMOSC_SRC_MAIN:
        if (next_src == CMOSC_SRC_RING)
          next_mode[7:6] = CMOSC_DIV_RING8;
      CMOSC_SRC_RING:
        ;
      default:
        next_src = CMOSC_SRC_RING;
    endcase
  end

  always_comb
  begin
    next_det_active = det_active;
    next_stop_rst_en = stop_rst_en;
    next_status = status;
    next_rst_cnt = (rst_cnt != 8'h00) ? rst_cnt - 8'h01 : 8'h00;
    if (DET_ACTIVE_WR)
      next_det_active = DET_ACTIVE_WDATA;
    if (STOP_RST_EN_WR)
      next_stop_rst_en = STOP_RST_EN_WDATA;
    if (DET_ACTIVE_WR && !DET_ACTIVE_WDATA)
      next_status = 1'b0;
    // detection sets after the clear so a coincident event is kept
    if (det_active && stopped)
    begin
      next_status = 1'b1;
      if (stop_rst_en && !int_rst)
        next_rst_cnt = CMOSC_RST_CYCLES;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      mode <= CMOSC_MODE_RESET;
      locked <= 1'b0;
      src <= CMOSC_SRC_RING;
      det_active <= 1'b0;
      stop_rst_en <= 1'b0;
      status <= 1'b0;
      rst_cnt <= 8'h00;
    end
    else if (int_rst)
    begin
      // internal reset restarts the clock setup but spares the detector
      mode <= CMOSC_MODE_RESET;
      locked <= 1'b0;
      src <= CMOSC_SRC_RING;
      det_active <= det_active;
      stop_rst_en <= 1'b0;
      status <= status;
      rst_cnt <= next_rst_cnt;
    end
    else
    begin
      mode <= next_mode;
      locked <= next_locked;
      src <= next_src;
      det_active <= next_det_active;
      stop_rst_en <= next_stop_rst_en;
      status <= next_status;
      rst_cnt <= next_rst_cnt;
    end
  end

  assign MODE_RDATA = mode;
  assign DET_ACTIVE = det_active;
  assign STOP_RST_EN = stop_rst_en;
  assign STOP_STATUS = status;
  assign MODE_LOCKED = locked;
  assign USE_MAIN_OSC = src == CMOSC_SRC_MAIN;
  assign RC_MODE = mode[CMOSC_BIT_OSC_SEL];
  assign MAIN_OSC_RUN = !mode[CMOSC_BIT_MAIN_STOP];
  assign RING_OSC_RUN = !mode[CMOSC_BIT_RING_STOP];
  assign DIV_SEL = mode[7:6];
  assign INT_RST = int_rst;
endmodule : cmosc_ctrl
`default_nettype wire

// *** logic/cmosc_pkg.sv ***
// package: constants for the clock mode and oscillation-stop control block
package cmosc_pkg;
  localparam logic [7:0] CMOSC_MODE_RESET = 8'h80;
  localparam int CMOSC_BIT_DIV_HI = 7;
  localparam int CMOSC_BIT_DIV_LO = 6;
  localparam int CMOSC_BIT_OSC_SEL = 5;
  localparam int CMOSC_BIT_MAIN_STOP = 4;
  localparam int CMOSC_BIT_RING_STOP = 3;
  localparam logic [7:0] CMOSC_ONCE_MASK = 8'h23;
  localparam logic [1:0] CMOSC_DIV_RING8 = 2'h2;
  localparam int CMOSC_STOP_NS = 1000;
  localparam int CMOSC_CLK_NS = 10;
  localparam logic [7:0] CMOSC_STOP_CYCLES = 8'(CMOSC_STOP_NS / CMOSC_CLK_NS);
  localparam logic [7:0] CMOSC_RST_CYCLES = 8'h10;
  typedef enum logic [1:0] {CMOSC_WR_NONE, CMOSC_WR_FULL, CMOSC_WR_BIT}
    cmosc_wr_t;
  typedef enum {CMOSC_SRC_RING, CMOSC_SRC_MAIN} cmosc_src_t;
endpackage : cmosc_pkg

// *** logic/cmosc_stop_det.sv ***
// main oscillator stop detector: counts cycles without an input edge
`timescale 1ns/1ps
`default_nettype none
module cmosc_stop_det
  import cmosc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic osc_in,
  output logic stopped
);
  logic sync1, sync2, prev;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_stopped;

  always_comb
  begin
    next_cnt = cnt;
    next_stopped = stopped;
    if (!enable || (sync2 != prev))
    begin
      next_cnt = 8'h00;
      next_stopped = 1'b0;
    end
    else if (cnt == CMOSC_STOP_CYCLES)
      next_stopped = 1'b1;
    else
      next_cnt = cnt + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
      cnt <= 8'h00;
      stopped <= 1'b0;
    end
    else
    begin
      sync1 <= osc_in;
      sync2 <= sync1;
      prev <= sync2;
      cnt <= next_cnt;
      stopped <= next_stopped;
    end
  end
endmodule : cmosc_stop_det
`default_nettype wire

// *** tb/cmosc_ctrl_properties.sv ***
// checker: clock mode lock and oscillation-stop reset properties
`timescale 1ns/1ps
`default_nettype none
module cmosc_ctrl_chk
  import cmosc_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic MODE_WR,
  input wire logic MODE_BIT_OP,
  input wire logic [7:0] MODE_RDATA,
  input wire logic DET_ACTIVE_WR,
  input wire logic DET_ACTIVE_WDATA,
  input wire logic DET_ACTIVE,
  input wire logic STOP_RST_EN,
  input wire logic STOP_STATUS,
  input wire logic MODE_LOCKED,
  input wire logic USE_MAIN_OSC,
  input wire logic INT_RST
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence hold8_s;
    INT_RST [*8];
  endsequence
  boot_ring_a: assert property ($fell(SYS_RST) |->
    MODE_RDATA == 8'h80 && !USE_MAIN_OSC) else $error("boot state");
  once_keep_a: assert property (MODE_LOCKED && !INT_RST |=> INT_RST ||
    (MODE_RDATA & 8'h23) == $past(MODE_RDATA & 8'h23)) else $error("relock");
  bitop_lock_a: assert property (MODE_WR && MODE_BIT_OP && !INT_RST
    |=> MODE_LOCKED) else $error("bit op no lock");
  leave_main_a: assert property ($fell(USE_MAIN_OSC) |->
    MODE_RDATA[7:6] == 2'h2) else $error("ring not div8");
  no_rst_a: assert property ($rose(INT_RST) |->
    $past(STOP_RST_EN)) else $error("reset while off");
  int_len_a: assert property ($rose(INT_RST) |->
    hold8_s ##1 hold8_s ##1 !INT_RST) else $error("reset length");
  keep_det_a: assert property (INT_RST |->
    $stable(DET_ACTIVE)) else $error("detector dropped");
  status_clr_a: assert property ($fell(STOP_STATUS) |->
    $past(DET_ACTIVE_WR && !DET_ACTIVE_WDATA)) else $error("status lost");
endmodule : cmosc_ctrl_chk
bind cmosc_ctrl cmosc_ctrl_chk chk_u (.CLK, .SYS_RST, .MODE_WR,
  .MODE_BIT_OP, .MODE_RDATA, .DET_ACTIVE_WR, .DET_ACTIVE_WDATA,
  .DET_ACTIVE, .STOP_RST_EN, .STOP_STATUS, .MODE_LOCKED,
  .USE_MAIN_OSC, .INT_RST);
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: mode register lock, clock source and stop reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic CLK = 1'b0, SYS_RST = 1'b1, MODE_WR = 1'b0, MODE_BIT_OP = 1'b0;
  logic [7:0] MODE_WDATA = 8'h00, MODE_RDATA;
  logic MAIN_OSC_INPUT = 1'b0, DET_ACTIVE_WR = 1'b0, osc_on = 1'b0;
  logic DET_ACTIVE_WDATA = 1'b0, STOP_RST_EN_WR = 1'b0;
  logic STOP_RST_EN_WDATA = 1'b0, DET_ACTIVE, STOP_RST_EN, STOP_STATUS;
  logic MODE_LOCKED, USE_MAIN_OSC, RC_MODE, MAIN_OSC_RUN, RING_OSC_RUN;
  logic [1:0] DIV_SEL;
  logic INT_RST;
  int mismatches = 0, n_tests = 0;
  cmosc_ctrl dut_u (.CLK, .SYS_RST, .MODE_WR, .MODE_BIT_OP, .MODE_WDATA,
    .MODE_RDATA, .MAIN_OSC_INPUT, .DET_ACTIVE_WR, .DET_ACTIVE_WDATA,
    .STOP_RST_EN_WR, .STOP_RST_EN_WDATA, .DET_ACTIVE, .STOP_RST_EN,
    .STOP_STATUS, .MODE_LOCKED, .USE_MAIN_OSC, .RC_MODE, .MAIN_OSC_RUN,
    .RING_OSC_RUN, .DIV_SEL, .INT_RST);
  initial
  begin
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) if (osc_on) MAIN_OSC_INPUT <= ~MAIN_OSC_INPUT;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rst();
    SYS_RST <= 1'b1;
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
  endtask : rst
  // the first edge takes the write, two more edges follow before the outputs are checked
  task automatic wr(input logic [7:0] d, input logic b);
    MODE_WR <= 1'b1;
    MODE_BIT_OP <= b;
    MODE_WDATA <= d;
    @(posedge CLK);
    MODE_WR <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : wr
  task automatic fl(input logic det, input logic d);
    DET_ACTIVE_WR <= det;
    STOP_RST_EN_WR <= !det;
    DET_ACTIVE_WDATA <= d;
    STOP_RST_EN_WDATA <= d;
    @(posedge CLK);
    DET_ACTIVE_WR <= 1'b0;
    STOP_RST_EN_WR <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : fl
  task automatic summarize();
    $display("%0d compares, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  initial
  begin
    #50us;
    mismatches++;
    summarize();
  end
  initial
  begin
    rst();
    chk(MODE_RDATA, cmosc_pkg::CMOSC_MODE_RESET);
    chk(USE_MAIN_OSC, 1'b0);
    // main oscillator starts toggling on the same edge as the write that selects it
    osc_on <= 1'b1;
    // rc mode with a plain division ratio, no double speed
    wr(8'h60, 1'b0);
    chk(RC_MODE, 1'b1);
    chk(USE_MAIN_OSC, 1'b1);
    chk(MAIN_OSC_RUN, 1'b1);
    wr(8'h0B, 1'b0);
    chk(MODE_RDATA, 8'h28);
    chk(RING_OSC_RUN, 1'b0);
    wr(8'h10, 1'b0);
    chk(MODE_RDATA, 8'hB0);
    chk(DIV_SEL, 2'h2);
    chk(MAIN_OSC_RUN, 1'b0);
    $display("mode test done");
    rst();
    wr(8'h84, 1'b1);
    wr(8'hA3, 1'b0);
    chk(MODE_RDATA, 8'h80);
    chk(RC_MODE, 1'b0);
    rst();
    wr(8'h94, 1'b0);
    chk(MODE_RDATA, 8'h94);
    chk(USE_MAIN_OSC, 1'b0);
    chk(MAIN_OSC_RUN, 1'b0);
    $display("bit op test done");
    rst();
    osc_on <= 1'b0;
    fl(1'b1, 1'b1);
    repeat (150) @(posedge CLK);
    chk(STOP_STATUS, 1'b1);
    chk(INT_RST, 1'b0);
    rst();
    chk(STOP_STATUS, 1'b0);
    osc_on <= 1'b1;
    fl(1'b0, 1'b1);
    fl(1'b1, 1'b1);
    osc_on <= 1'b0;
    for (int i = 0; i < 300 && INT_RST !== 1'b1; i++) @(posedge CLK);
    chk(INT_RST, 1'b1);
    repeat (20) @(posedge CLK);
    chk(DET_ACTIVE, 1'b1);
    chk(STOP_RST_EN, 1'b0);
    // a pending stop event would win over the clear, so restart the clock
    osc_on <= 1'b1;
    repeat (6) @(posedge CLK);
    fl(1'b1, 1'b0);
    chk(STOP_STATUS, 1'b0);
    $display("stop test done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
